//--- core/irq_gpio_mux.sv
`timescale 1ns/1ns
`default_nettype none
`include "irq_gpio_params.svh"

module irq_gpio_mux #(
  parameter int ADDR_W = 10
) (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  input  wire logic [ADDR_W-1:0]      regAddr,
  input  wire logic [7:0]             regWdata,
  output logic      [7:0]             regRdata,
  input  wire irq_gpio_pkg::flag_set_s flagSet,
  input  wire irq_gpio_pkg::monitor_s  mon,
  input  wire irq_gpio_pkg::pin_ctrl_s pinCtrl,
  input  wire logic [2:0]             gpioIn,
  output logic      [2:0]             gpioOut,
  output logic      [2:0]             gpioOutEn,
  output logic                        irqOutN
);

  // offsets are 10 bits wide; a narrower port would alias registers onto each other
  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W must hold the 10-bit register offsets");
  end

  // flags[0..3] = core, tx, rx, misc; enables likewise
  logic [7:0]             flags [4];
  logic [7:0]             enables [4];
  logic                   globalIrqEnable;
  irq_gpio_pkg::pin_func_e pinFunctionSelect;
  logic                   gainHoldFlag;
  logic                   irqPending;
  logic [7:0]             setVec [4];
  logic [2:0]             pinEventSet;
  logic                   modeNormal;

  // offset of flag register n or enable register n, n in 0..3
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  function automatic logic [7:0] implMask(input int n);
    case (n)
      0:       implMask = `MASK_CORE;
      1:       implMask = `MASK_TX;
      2:       implMask = `MASK_RX;
      default: implMask = `MASK_MISC;
    endcase
  endfunction

  function automatic logic [9:0] flagOff(input int n);
    flagOff = `OFF_CORE_FLAGS + 10'(n);
  endfunction

  function automatic logic [9:0] enOff(input int n);
    enOff = `OFF_CORE_EN + 10'(n);
  endfunction

  assign modeNormal = (pinFunctionSelect == irq_gpio_pkg::FUNC_NORMAL);

  // pin flags: only meaningful when the host owns the pin as an input
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pinEventSet[i] = modeNormal && pinCtrl.pinCtrlEnable && pinCtrl.pinIsInput[i] &&
                       (gpioIn[i] == pinCtrl.pinPolarity[i]);
    end
  end

  // collect set requests; reserved positions can never set
  always_comb begin
    setVec[0] = flagSet.core & `MASK_CORE;
    setVec[1] = flagSet.tx & `MASK_TX;
    setVec[2] = flagSet.rx & `MASK_RX;
    setVec[3] = {flagSet.misc[7:3], pinEventSet} & `MASK_MISC;
  end

  // flags clear on host read; a set in the same cycle wins over the clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int n = 0; n < 4; n++) flags[n] <= 8'h00;
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (regWrite && hit(regAddr, flagOff(n))) begin
          flags[n] <= (regWdata & implMask(n)) | setVec[n];
        end else if (regRead && hit(regAddr, flagOff(n))) begin
          flags[n] <= setVec[n];
        end else begin
          flags[n] <= flags[n] | setVec[n];
        end
      end
    end
  end

  // enable registers; reserved bits are dropped so they read zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      enables[0] <= `RST_CORE_EN;
      enables[1] <= `RST_TX_EN;
      enables[2] <= `RST_RX_EN;
      enables[3] <= `RST_MISC_EN;
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (regWrite && hit(regAddr, enOff(n))) begin
          enables[n] <= regWdata & implMask(n);
        end
      end
    end
  end

  // pin configuration: global enable and function select
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      globalIrqEnable   <= `RST_GLOBAL_EN;
      pinFunctionSelect <= irq_gpio_pkg::FUNC_NORMAL;
    end else if (regWrite && hit(regAddr, `OFF_PIN_CFG)) begin
      globalIrqEnable   <= regWdata[`POS_GLOBAL_EN];
      // reserved codes are stored as written; pins then go undriven
      pinFunctionSelect <= irq_gpio_pkg::pin_func_e'(regWdata[`MSB_FUNC:0]);
    end
  end

  // pending is combinational so it never lags the flags by more than the pin flop
  always_comb begin
    irqPending = 1'b0;
    for (int n = 0; n < 4; n++) begin
      irqPending = irqPending | (|(flags[n] & enables[n]));
    end
  end

  // interrupt pin is active low and gated by the global enable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irqOutN <= 1'b1;
    end else begin
      irqOutN <= !(irqPending && globalIrqEnable);
    end
  end

  // gain hold: preamble sets it, release after the frame clears it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gainHoldFlag <= 1'b0;
    end else if (mon.preambleSeen) begin
      gainHoldFlag <= 1'b1;
    end else if (mon.gainRelease) begin
      gainHoldFlag <= 1'b0;
    end
  end

  // pin function mux; every listed mode but normal and timesync drives all pins itself
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gpioOut   <= 3'h0;
      gpioOutEn <= 3'h0;
    end else begin
      case (pinFunctionSelect)
        irq_gpio_pkg::FUNC_NORMAL: begin
          gpioOut   <= pinCtrl.pinOutValue;
          gpioOutEn <= pinCtrl.pinCtrlEnable ? ~pinCtrl.pinIsInput : 3'h0;
        end
        irq_gpio_pkg::FUNC_GAIN_MON: begin
          gpioOut   <= {gainHoldFlag, mon.gain};
          gpioOutEn <= 3'h7;
        end
        irq_gpio_pkg::FUNC_RX_FSM: begin
          gpioOut   <= mon.rxState;
          gpioOutEn <= 3'h7;
        end
        irq_gpio_pkg::FUNC_MAC_MON: begin
          gpioOut   <= mon.mac_op_code[3:1];
          gpioOutEn <= 3'h7;
        end
        irq_gpio_pkg::FUNC_RADIO: begin
          gpioOut   <= mon.radioOp;
          gpioOutEn <= 3'h7;
        end
        irq_gpio_pkg::FUNC_TIMESYNC: begin
          // pin 2 stays a host pin so a sync design can keep one spare line
          gpioOut   <= {pinCtrl.pinOutValue[2], mon.rxSfdPulse, mon.txSfdPulse};
          gpioOutEn <= {pinCtrl.pinCtrlEnable & ~pinCtrl.pinIsInput[2], 2'b11};
        end
        irq_gpio_pkg::FUNC_TX_STRM: begin
          gpioOut   <= {mon.txBufReading, mon.busBufWriting, mon.tx_buf_empty_a};
          gpioOutEn <= 3'h7;
        end
        irq_gpio_pkg::FUNC_RX_STRM: begin
          gpioOut   <= {mon.rxBufWriting, mon.busBufReading, mon.rxBufFull};
          gpioOutEn <= 3'h7;
        end
        default: begin
          // reserved codes: release the pins rather than guess a function
          gpioOut   <= 3'h0;
          gpioOutEn <= 3'h0;
        end
      endcase
    end
  end

  // registered read data; unmapped offsets read zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= 8'h00;
      for (int n = 0; n < 4; n++) begin
        if (hit(regAddr, flagOff(n))) regRdata <= flags[n];
        if (hit(regAddr, enOff(n)))   regRdata <= enables[n];
      end
      if (hit(regAddr, `OFF_PIN_CFG)) begin
        regRdata <= {1'b0, globalIrqEnable, 1'b0, irqPending, pinFunctionSelect};
      end
    end
  end

  // ---- checks ----
  sequence s_hold_set;
    mon.preambleSeen ##1 gainHoldFlag;
  endsequence

  sequence s_release;
    (!mon.preambleSeen && mon.gainRelease);
  endsequence

  property p_irq_low;
    @(posedge core_clk) disable iff (!resetn)
      (irqPending && globalIrqEnable) |=> !irqOutN;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq pin not low while pending");

  property p_irq_gated;
    @(posedge core_clk) disable iff (!resetn)
      !globalIrqEnable |=> irqOutN;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq pin active with global enable off");

  property p_enabled_set_pends;
    @(posedge core_clk) disable iff (!resetn)
      (flagSet.tx[7] && enables[1][7] && !(regWrite && hit(regAddr, `OFF_TX_EN)))
        |=> irqPending ##1 (!irqOutN || !$past(globalIrqEnable));
  endproperty
  a_enabled_set_pends: assert property (p_enabled_set_pends) else $error("enabled flag did not pend");

  property p_masked_silent;
    @(posedge core_clk) disable iff (!resetn)
      (enables[0] == 8'h00 && enables[1] == 8'h00 && enables[2] == 8'h00 && enables[3] == 8'h00)
        |-> !irqPending;
  endproperty
  a_masked_silent: assert property (p_masked_silent) else $error("pending with all enables clear");

  property p_read_clears;
    @(posedge core_clk) disable iff (!resetn)
      (regRead && !regWrite && hit(regAddr, `OFF_RX_FLAGS) && flagSet.rx == 8'h00) |=> flags[2] == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag register not cleared by read");

  property p_set_beats_read;
    @(posedge core_clk) disable iff (!resetn)
      (regRead && hit(regAddr, `OFF_TX_FLAGS) && flagSet.tx[0]) |=> flags[1][0];
  endproperty
  a_set_beats_read: assert property (p_set_beats_read) else $error("set lost under read clear");

  property p_hold_cycle;
    @(posedge core_clk) disable iff (!resetn)
      s_hold_set ##[1:8] s_release |=> !gainHoldFlag;
  endproperty
  a_hold_cycle: assert property (p_hold_cycle) else $error("gain hold did not follow preamble and release");

  property p_gain_pins;
    @(posedge core_clk) disable iff (!resetn)
      (pinFunctionSelect == irq_gpio_pkg::FUNC_GAIN_MON) |=>
        (gpioOut == {$past(gainHoldFlag), $past(mon.gain)}) && gpioOutEn == 3'h7;
  endproperty
  a_gain_pins: assert property (p_gain_pins) else $error("gain monitor pins wrong");

  property p_sync_pulses;
    @(posedge core_clk) disable iff (!resetn)
      (pinFunctionSelect == irq_gpio_pkg::FUNC_TIMESYNC && mon.txSfdPulse) |=> gpioOut[0] && gpioOutEn[0];
  endproperty
  a_sync_pulses: assert property (p_sync_pulses) else $error("tx sfd pulse missing on pin 0");

  property p_pin_flag_gate;
    @(posedge core_clk) disable iff (!resetn)
      (!modeNormal && !(regWrite && hit(regAddr, `OFF_MISC_FLAGS)) &&
       !(regRead && hit(regAddr, `OFF_MISC_FLAGS))) |=> flags[3][2:0] == $past(flags[3][2:0]);
  endproperty
  a_pin_flag_gate: assert property (p_pin_flag_gate) else $error("pin flag set outside normal mode");

  property p_mac_pins;
    @(posedge core_clk) disable iff (!resetn)
      (pinFunctionSelect == irq_gpio_pkg::FUNC_MAC_MON) |=> gpioOut == $past(mon.mac_op_code[3:1]);
  endproperty
  a_mac_pins: assert property (p_mac_pins) else $error("mac monitor pins wrong");

endmodule // irq_gpio_mux

`default_nettype wire

//--- core/irq_gpio_params.svh
`ifndef IRQ_GPIO_PARAMS_SVH
`define IRQ_GPIO_PARAMS_SVH

// register offsets on the host register port
`define OFF_CORE_FLAGS  10'h004
`define OFF_TX_FLAGS    10'h005
`define OFF_RX_FLAGS    10'h006
`define OFF_MISC_FLAGS  10'h007
`define OFF_CORE_EN     10'h008
`define OFF_TX_EN       10'h009
`define OFF_RX_EN       10'h00A
`define OFF_MISC_EN     10'h00B
`define OFF_PIN_CFG     10'h00C

// reset values of the enable registers and pin configuration
`define RST_CORE_EN     8'h36
`define RST_TX_EN       8'hDF
`define RST_RX_EN       8'hE3
`define RST_MISC_EN     8'h38
`define RST_GLOBAL_EN   1'b1

// implemented bits; reserved positions read zero
`define MASK_CORE       8'h36
`define MASK_TX         8'hFF
`define MASK_RX         8'hEF
`define MASK_MISC       8'hFF

// field positions in pin_configuration
`define POS_GLOBAL_EN   6
`define POS_PENDING     4
`define MSB_FUNC        3

`endif

//--- core/irq_gpio_pkg.sv
package irq_gpio_pkg;

  // pin function select codes; anything not listed is reserved
  typedef enum logic [3:0] {
    FUNC_NORMAL   = 4'b0000,
    FUNC_GAIN_MON = 4'b0001,
    FUNC_RX_FSM   = 4'b0010,
    FUNC_MAC_MON  = 4'b0011,
    FUNC_RADIO    = 4'b0100,
    FUNC_TIMESYNC = 4'b0101,
    FUNC_TX_STRM  = 4'b1010,
    FUNC_RX_STRM  = 4'b1011
  } pin_func_e;

  // one-cycle set requests for the four flag registers
  typedef struct packed {
    logic [7:0] core;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] misc;
  } flag_set_s;

  // internal state sampled for pin monitoring
  typedef struct packed {
    logic       preambleSeen;
    logic       gainRelease;
    logic [1:0] gain;
    logic [2:0] rxState;
    logic [3:0] mac_op_code;
    logic [2:0] radioOp;
    logic       txSfdPulse;
    logic       rxSfdPulse;
    logic       txBufReading;
    logic       busBufWriting;
    logic       tx_buf_empty_a;
    logic       rxBufWriting;
    logic       busBufReading;
    logic       rxBufFull;
  } monitor_s;

  // host-owned general purpose pin settings
  typedef struct packed {
    logic       pinCtrlEnable;
    logic [2:0] pinIsInput;
    logic [2:0] pinOutValue;
    logic [2:0] pinPolarity;
  } pin_ctrl_s;

endpackage

//--- testbench/host_reg_model.sv
`timescale 1ns/1ns
`default_nettype none
// host side of the register port; strobes change just after a rising edge
module host_reg_model (
  input  wire logic       core_clk,
  output logic            regWrite,
  output logic            regRead,
  output logic      [9:0] regAddr,
  output logic      [7:0] regWdata
);
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 10'h3FF;
    regWdata = 8'h00;
  end

  // callers keep reserved bits and function codes legal unless a refusal is meant
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regAddr  <= ~a; // released lines show no stale value
    regWdata <= ~d;
  endtask

  // one-cycle read strobe; the read itself clears a flag register
  task automatic rd(input logic [9:0] a);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
  endtask
endmodule // host_reg_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "irq_gpio_params.svh"
module tb_top;
  logic                    core_clk = 1'b0;
  logic                    resetn   = 1'b0;
  logic                    regWrite;
  logic                    regRead;
  logic [9:0]              regAddr;
  logic [7:0]              regWdata;
  logic [7:0]              regRdata;
  irq_gpio_pkg::flag_set_s flagSet  = '0;
  irq_gpio_pkg::monitor_s  mon      = '0;
  irq_gpio_pkg::monitor_s  m;
  irq_gpio_pkg::pin_ctrl_s pinCtrl  = '0;
  logic [2:0]              gpioIn   = 3'h0;
  logic [2:0]              gpioOut;
  logic [2:0]              gpioOutEn;
  logic                    irqOutN;
  logic                    rdSeen   = 1'b0;
  logic [7:0]              expQ[$];
  int                      error_cnt = 0;
  int                      cmp_count = 0;
  int                      cycles    = 0;
  int                      seed      = 62553;
  logic [7:0]              msk[4]   = '{8'h36, 8'hFF, 8'hEF, 8'hF8};
  logic [7:0]              rstv[5]  = '{8'h36, 8'hDF, 8'hE3, 8'h38, 8'h40};
  logic [3:0]              funcs[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hA, 4'hB, 4'h6, 4'hC};

  always #2 core_clk = ~core_clk;

  irq_gpio_mux dut (
    .core_clk (core_clk),
    .resetn   (resetn),
    .regWrite (regWrite),
    .regRead  (regRead),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .regRdata (regRdata),
    .flagSet  (flagSet),
    .mon      (mon),
    .pinCtrl  (pinCtrl),
    .gpioIn   (gpioIn),
    .gpioOut  (gpioOut),
    .gpioOutEn(gpioOutEn),
    .irqOutN  (irqOutN)
  );

  host_reg_model host (
    .core_clk(core_clk),
    .regWrite(regWrite),
    .regRead (regRead),
    .regAddr (regAddr),
    .regWdata(regWdata)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // note the expected read data, then issue the read
  task automatic rdx(input logic [9:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask

  // one-cycle set request on every bit of v in flag register r
  task automatic pulse(input int r, input logic [7:0] v);
    @(posedge core_clk);
    flagSet <= irq_gpio_pkg::flag_set_s'(32'(v) << (8 * (3 - r)));
    @(posedge core_clk);
    flagSet <= '0;
  endtask

  // expected {enables, driven values} of the three pins for a function code
  function automatic logic [5:0] expPins(input logic [3:0] f);
    logic [2:0] hen;
    hen = pinCtrl.pinCtrlEnable ? ~pinCtrl.pinIsInput : 3'h0;
    case (f)
      4'h0: return {hen, pinCtrl.pinOutValue & hen};
      4'h1: return {3'h7, 1'b0, mon.gain};
      4'h2: return {3'h7, mon.rxState};
      4'h3: return {3'h7, mon.mac_op_code[3:1]};
      4'h4: return {3'h7, mon.radioOp};
      4'h5: return {hen[2], 2'b11, pinCtrl.pinOutValue[2] & hen[2], mon.rxSfdPulse, mon.txSfdPulse};
      4'hA: return {3'h7, mon.txBufReading, mon.busBufWriting, mon.tx_buf_empty_a};
      4'hB: return {3'h7, mon.rxBufWriting, mon.busBufReading, mon.rxBufFull};
      default: return 6'h00;
    endcase
  endfunction

  // read data lands the cycle after the strobe; compare it off the edge
  always @(posedge core_clk) rdSeen <= regRead;
  always @(negedge core_clk) begin
    if (rdSeen) check(regRdata, expQ.pop_front());
  end

  // a hang is cut short well past the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    tick(16);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) rdx(10'(4 + i), 8'h00);
    for (int i = 0; i < 5; i++) rdx(10'(8 + i), rstv[i]);
    rdx(10'h3FF, 8'h00);
    #1 check({7'h0, irqOutN}, 8'h01);
    // reserved bits drop and the pending bit cannot be written
    host.wr(`OFF_CORE_EN, 8'hFF);
    rdx(`OFF_CORE_EN, 8'h36);
    host.wr(`OFF_RX_EN, 8'hFF);
    rdx(`OFF_RX_EN, 8'hEF);
    host.wr(`OFF_PIN_CFG, 8'hBF);
    rdx(`OFF_PIN_CFG, 8'h0F);
    host.wr(`OFF_PIN_CFG, 8'h40);
    for (int i = 0; i < 4; i++) host.wr(10'(8 + i), 8'h00);
    // every flag of a register set except the misc pin flags 2:0, only one enable open at a time
    for (int r = 0; r < 4; r++) begin
      for (int b = 0; b < 8; b++) begin
        host.wr(10'(8 + r), 8'h01 << b);
        pulse(r, 8'hFF);
        tick(3);
        #1 check({7'h0, irqOutN}, {7'h0, ~msk[r][b]});
        rdx(`OFF_PIN_CFG, {3'b010, msk[r][b], 4'h0});
        rdx(10'(4 + r), msk[r]);
        rdx(`OFF_PIN_CFG, 8'h40);
        #1 check({7'h0, irqOutN}, 8'h01);
        host.wr(10'(8 + r), 8'h00);
      end
    end
    // global enable off holds the pin inactive while pending stays visible
    host.wr(`OFF_CORE_EN, 8'h20);
    pulse(0, 8'h20);
    host.wr(`OFF_PIN_CFG, 8'h00);
    tick(3);
    #1 check({7'h0, irqOutN}, 8'h01);
    rdx(`OFF_PIN_CFG, 8'h10);
    host.wr(`OFF_PIN_CFG, 8'h40);
    tick(3);
    #1 check({7'h0, irqOutN}, 8'h00);
    rdx(`OFF_CORE_FLAGS, 8'h20);
    // every listed function code plus reserved codes 6 and C, with random monitor state
    for (int i = 0; i < 10; i++) begin
      m = irq_gpio_pkg::monitor_s'(22'($random(seed)));
      m.preambleSeen = 1'b0;
      m.gainRelease = 1'b0;
      @(posedge core_clk);
      mon <= m;
      pinCtrl <= irq_gpio_pkg::pin_ctrl_s'(10'($random(seed)));
      host.wr(`OFF_PIN_CFG, {4'h4, funcs[i]});
      tick(3);
      #1 check({2'b00, gpioOutEn, gpioOut & gpioOutEn}, {2'b00, expPins(funcs[i])});
    end
    // gain hold sets on preamble, persists, clears on release
    host.wr(`OFF_PIN_CFG, 8'h41);
    // random pin settings in normal mode may have left pin flags behind; wipe them
    host.wr(`OFF_MISC_FLAGS, 8'h00);
    rdx(`OFF_MISC_FLAGS, 8'h00);
    @(posedge core_clk);
    mon.preambleSeen <= 1'b1;
    @(posedge core_clk);
    mon.preambleSeen <= 1'b0;
    tick(5);
    #1 check({7'h0, gpioOut[2]}, 8'h01);
    @(posedge core_clk);
    mon.gainRelease <= 1'b1;
    @(posedge core_clk);
    mon.gainRelease <= 1'b0;
    tick(2);
    #1 check({7'h0, gpioOut[2]}, 8'h00);
    // pin flags follow level against polarity, only in normal mode
    @(posedge core_clk);
    pinCtrl <= '{pinCtrlEnable: 1'b1, pinIsInput: 3'h7, pinOutValue: 3'h0, pinPolarity: 3'h5};
    gpioIn <= 3'b100;
    host.wr(`OFF_PIN_CFG, 8'h40);
    host.wr(`OFF_MISC_EN, 8'h02);
    tick(3);
    #1 check({7'h0, irqOutN}, 8'h00);
    rdx(`OFF_MISC_FLAGS, 8'h06);
    host.wr(`OFF_PIN_CFG, 8'h41);
    tick(2);
    rdx(`OFF_MISC_FLAGS, 8'h06);
    rdx(`OFF_MISC_FLAGS, 8'h00);
    // a set in the read's own cycle survives the read clear
    fork
      pulse(1, 8'h01);
      rdx(`OFF_TX_FLAGS, 8'h00);
    join
    rdx(`OFF_TX_FLAGS, 8'h01);
    // a mid-run reset brings every enable and the pin configuration back
    @(posedge core_clk);
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) rdx(10'(8 + i), rstv[i]);
    tick(2);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
